/* File: tkf_pkg.sv */
// Package for the touchkey filter block: register offsets, field layout, reset values.
// Assumes byte-wide register access from the device's internal host interface.
package tkf_pkg;
  localparam int unsigned TKF_NCH = 24;
  localparam int unsigned TKF_IMP_W = 13;
  localparam int unsigned TKF_THR_W = 13;
  localparam logic [7:0] TKF_KEY_FILTER_CONFIG_ADDR = 8'h90;
  localparam logic [7:0] TKF_GROUP_ONE_MASK_ADDR = 8'h92;
  localparam logic [7:0] TKF_GROUP_TWO_MASK_ADDR = 8'h96;
  localparam logic [7:0] TKF_FILTERED_STATUS_ADDR = 8'h9a;
  localparam logic [7:0] TKF_LIVE_STATUS_ADDR = 8'hb4;
  localparam int unsigned TKF_MODE_ONE_LSB = 0;
  localparam int unsigned TKF_MODE_TWO_LSB = 2;
  localparam logic [7:0] TKF_CONFIG_RESET = 8'h00;
  localparam logic [23:0] TKF_MASK_RESET = 24'h000000;
  localparam logic [23:0] TKF_STATUS_RESET = 24'h000000;
  localparam logic [1:0] TKF_MODE_OFF = 2'h0;
  typedef enum logic [2:0]
  {
    TKF_ST_IDLE = 3'b001,
    TKF_ST_SCAN = 3'b010,
    TKF_ST_DONE = 3'b100
  } tkf_scan_t;
endpackage : tkf_pkg

/* File: tkf_rank_unit.sv */
// Key filter unit: keeps the largest 1..3 impedance changes among touched group channels.
// Assumes the deltas stay stable during a scan; the parent starts one scan at a time.
`timescale 1ns/10ps
module tkf_rank_unit
  import tkf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [1:0] i_mode,
  input wire logic [TKF_NCH-1:0] i_group,
  input wire logic [TKF_NCH-1:0] i_touch,
  input wire logic [TKF_NCH*TKF_IMP_W-1:0] i_delta,
  output logic [TKF_NCH-1:0] o_keep
);
  typedef struct packed
  {
    logic [TKF_NCH-1:0] keep;
  } tkf_rank_state_t;
  tkf_rank_state_t st_ff;
  tkf_rank_state_t nxt_st;
  logic [TKF_NCH-1:0] cand;
  logic [TKF_NCH-1:0] sel;
  logic [4:0] best_idx;
  logic [TKF_IMP_W-1:0] best_val;
  logic found;

  assign o_keep = st_ff.keep;

  always_comb
  begin
    sel = '0;
    cand = i_group & i_touch;
    best_idx = 5'h00;
    best_val = '0;
    found = 1'b0;
    for (int r = 0; r < 3; r++)
    begin
      found = 1'b0;
      best_idx = 5'h00;
      best_val = '0;
      for (int c = 0; c < TKF_NCH; c++)
      begin
        if (cand[c] && !sel[c] && (!found || i_delta[c*TKF_IMP_W +: TKF_IMP_W] > best_val))
        begin
          found = 1'b1;
          best_idx = 5'(c);
          best_val = i_delta[c*TKF_IMP_W +: TKF_IMP_W];
        end
      end
      if (found && (r < int'(i_mode)))
      begin
        sel[best_idx] = 1'b1;
      end
    end
    nxt_st = st_ff;
    if (i_start)
    begin
      nxt_st.keep = (i_mode == TKF_MODE_OFF) ? {TKF_NCH{1'b1}} : (~i_group | sel);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff <= '{keep: {TKF_NCH{1'b1}}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : tkf_rank_unit

/* File: tkf_key_filter.sv */
// Contract
// - Each channel's measurement becomes one touched or not-touched bit.
// - Two independent filter units cap active keys, ranked by impedance change.
// - Mode bits 1:0: 00 off, else keep 1/2/3 largest group-one changes.
// - Mode bits 3:2 use the same coding for group two.
// - Each group mask is 24 bits, low byte first, one selects channel.
// - Filtered status reads one per touched channel after filtering, three bytes.
// - Filtered status always updates; unfiltered status when filtering is off.
// - Live status gives unbuffered per-channel touch compare with hysteresis.
// - Touched when impedance departs calibration by more than channel threshold.
//
// Top of the touchkey back end: touch compare, two filter units, byte registers.
// Assumes impedance, calibration and thresholds arrive synchronous to i_sys_clk.
`timescale 1ns/10ps
module tkf_key_filter
  import tkf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [TKF_NCH*TKF_IMP_W-1:0] i_impedance,
  input wire logic [TKF_NCH*TKF_IMP_W-1:0] i_calibrated,
  input wire logic [TKF_NCH*TKF_THR_W-1:0] i_touch_variance_threshold,
  input wire logic [TKF_NCH*TKF_THR_W-1:0] i_hysteresis,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack
);
  typedef struct packed
  {
    logic [7:0] key_filter_config;
    logic [TKF_NCH-1:0] filter_group_one_mask;
    logic [TKF_NCH-1:0] filter_group_two_mask;
    logic [TKF_NCH-1:0] live_touch_status;
    logic [TKF_NCH-1:0] filtered_key_status;
    tkf_scan_t scan;
    logic [7:0] rdata;
    logic ack;
  } tkf_state_t;

  tkf_state_t st_ff;
  tkf_state_t nxt_st;
  logic [TKF_NCH*TKF_IMP_W-1:0] delta;
  logic [TKF_NCH-1:0] keep_one;
  logic [TKF_NCH-1:0] keep_two;
  logic start_scan;

  function automatic logic [TKF_IMP_W-1:0] abs_diff(input logic [TKF_IMP_W-1:0] a,
                                                    input logic [TKF_IMP_W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction : abs_diff

  function automatic logic [7:0] byte_of(input logic [TKF_NCH-1:0] v, input logic [1:0] sel);
    byte_of = v[sel*8 +: 8];
  endfunction : byte_of

  always_comb
  begin
    for (int c = 0; c < TKF_NCH; c++)
    begin
      delta[c*TKF_IMP_W +: TKF_IMP_W] = abs_diff(i_impedance[c*TKF_IMP_W +: TKF_IMP_W],
                                                 i_calibrated[c*TKF_IMP_W +: TKF_IMP_W]);
    end
  end

  assign start_scan = (st_ff.scan == TKF_ST_SCAN);

  tkf_rank_unit u_unit_one
  (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(start_scan),
    .i_mode(st_ff.key_filter_config[TKF_MODE_ONE_LSB +: 2]),
    .i_group(st_ff.filter_group_one_mask),
    .i_touch(st_ff.live_touch_status),
    .i_delta(delta),
    .o_keep(keep_one)
  );

  tkf_rank_unit u_unit_two
  (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(start_scan),
    .i_mode(st_ff.key_filter_config[TKF_MODE_TWO_LSB +: 2]),
    .i_group(st_ff.filter_group_two_mask),
    .i_touch(st_ff.live_touch_status),
    .i_delta(delta),
    .o_keep(keep_two)
  );

  assign o_reg_rdata = st_ff.rdata;
  assign o_reg_ack = st_ff.ack;

  always_comb
  begin
    logic [TKF_IMP_W-1:0] d;
    logic [TKF_THR_W-1:0] thr;
    logic [1:0] bsel;
    d = '0;
    thr = '0;
    bsel = 2'h0;
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    for (int c = 0; c < TKF_NCH; c++)
    begin
      d = delta[c*TKF_IMP_W +: TKF_IMP_W];
      thr = i_touch_variance_threshold[c*TKF_THR_W +: TKF_THR_W];
      if (d > thr)
      begin
        nxt_st.live_touch_status[c] = 1'b1;
      end
      else if ({1'b0, d} + {1'b0, i_hysteresis[c*TKF_THR_W +: TKF_THR_W]} <= {1'b0, thr})
      begin
        nxt_st.live_touch_status[c] = 1'b0;
      end
    end
    // Free-running: sample, rank, publish, repeat
    case (st_ff.scan)
      TKF_ST_IDLE:
      begin
        nxt_st.scan = TKF_ST_SCAN;
      end
      TKF_ST_SCAN:
      begin
        nxt_st.scan = TKF_ST_DONE;
      end
      TKF_ST_DONE:
      begin
        nxt_st.filtered_key_status = st_ff.live_touch_status & keep_one & keep_two;
        nxt_st.scan = TKF_ST_IDLE;
      end
      default:
      begin
        nxt_st.scan = TKF_ST_IDLE;
      end
    endcase
    if (i_reg_wr)
    begin
      nxt_st.ack = 1'b1;
      case (i_reg_addr)
        TKF_KEY_FILTER_CONFIG_ADDR:
        begin
          nxt_st.key_filter_config = {4'h0, i_reg_wdata[3:0]};
        end
        TKF_GROUP_ONE_MASK_ADDR:
        begin
          nxt_st.filter_group_one_mask[7:0] = i_reg_wdata;
        end
        TKF_GROUP_ONE_MASK_ADDR + 8'h01:
        begin
          nxt_st.filter_group_one_mask[15:8] = i_reg_wdata;
        end
        TKF_GROUP_ONE_MASK_ADDR + 8'h02:
        begin
          nxt_st.filter_group_one_mask[23:16] = i_reg_wdata;
        end
        TKF_GROUP_TWO_MASK_ADDR:
        begin
          nxt_st.filter_group_two_mask[7:0] = i_reg_wdata;
        end
        TKF_GROUP_TWO_MASK_ADDR + 8'h01:
        begin
          nxt_st.filter_group_two_mask[15:8] = i_reg_wdata;
        end
        TKF_GROUP_TWO_MASK_ADDR + 8'h02:
        begin
          nxt_st.filter_group_two_mask[23:16] = i_reg_wdata;
        end
        default:
        begin
          // Status bytes are read-only; unmapped writes dropped
          nxt_st.ack = 1'b1;
        end
      endcase
    end
    else if (i_reg_rd)
    begin
      nxt_st.ack = 1'b1;
      nxt_st.rdata = 8'h00;
      if (i_reg_addr == TKF_KEY_FILTER_CONFIG_ADDR)
      begin
        nxt_st.rdata = st_ff.key_filter_config;
      end
      else if (i_reg_addr >= TKF_GROUP_ONE_MASK_ADDR && i_reg_addr < TKF_GROUP_ONE_MASK_ADDR + 8'h03)
      begin
        bsel = 2'(i_reg_addr - TKF_GROUP_ONE_MASK_ADDR);
        nxt_st.rdata = byte_of(st_ff.filter_group_one_mask, bsel);
      end
      else if (i_reg_addr >= TKF_GROUP_TWO_MASK_ADDR && i_reg_addr < TKF_GROUP_TWO_MASK_ADDR + 8'h03)
      begin
        bsel = 2'(i_reg_addr - TKF_GROUP_TWO_MASK_ADDR);
        nxt_st.rdata = byte_of(st_ff.filter_group_two_mask, bsel);
      end
      else if (i_reg_addr >= TKF_FILTERED_STATUS_ADDR && i_reg_addr < TKF_FILTERED_STATUS_ADDR + 8'h03)
      begin
        bsel = 2'(i_reg_addr - TKF_FILTERED_STATUS_ADDR);
        nxt_st.rdata = byte_of(st_ff.filtered_key_status, bsel);
      end
      else if (i_reg_addr >= TKF_LIVE_STATUS_ADDR && i_reg_addr < TKF_LIVE_STATUS_ADDR + 8'h03)
      begin
        bsel = 2'(i_reg_addr - TKF_LIVE_STATUS_ADDR);
        nxt_st.rdata = byte_of(st_ff.live_touch_status, bsel);
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff <= '{key_filter_config: TKF_CONFIG_RESET,
                 filter_group_one_mask: TKF_MASK_RESET,
                 filter_group_two_mask: TKF_MASK_RESET,
                 live_touch_status: TKF_STATUS_RESET,
                 filtered_key_status: TKF_STATUS_RESET,
                 scan: TKF_ST_IDLE,
                 rdata: 8'h00,
                 ack: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : tkf_key_filter

/* File: tkf_key_filter_assertions.sv */
// Checker for the touchkey filter byte register port.
// Assumes one-cycle strobes and a bind onto the top module.
`timescale 1ns/10ps
module tkf_key_filter_assertions
  import tkf_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [TKF_NCH*TKF_IMP_W-1:0] i_impedance,
  input wire logic [TKF_NCH*TKF_IMP_W-1:0] i_calibrated,
  input wire logic [TKF_NCH*TKF_THR_W-1:0] i_touch_variance_threshold,
  input wire logic [TKF_NCH*TKF_THR_W-1:0] i_hysteresis,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_ack
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  wire logic acc = i_reg_wr | i_reg_rd;
  // Write wins over read
  wire logic rdo = i_reg_rd & ~i_reg_wr;
  AST_ACK: assert property (acc |=> o_reg_ack) else $error("ack missing");
  AST_NO_ACK: assert property (!acc |=> !o_reg_ack) else $error("stray ack");
  AST_RDATA_HOLD: assert property (!rdo |=> $stable(o_reg_rdata)) else $error("rdata moved");
  AST_CFG_HIGH: assert property (rdo && i_reg_addr == 8'h90 |=> o_reg_rdata[7:4] == 4'h0)
    else $error("config high bits set");
  AST_CFG_BACK: assert property (i_reg_wr && i_reg_addr == 8'h90 ##1 !i_reg_wr ##1 rdo && i_reg_addr == 8'h90
    |=> o_reg_rdata[3:0] == $past(i_reg_wdata[3:0], 3)) else $error("config readback");
  AST_MASK_BACK: assert property (i_reg_wr && i_reg_addr inside {8'h92, 8'h93, 8'h94, 8'h96, 8'h97, 8'h98}
    ##1 !i_reg_wr ##1 rdo && i_reg_addr == $past(i_reg_addr, 2) |=> o_reg_rdata == $past(i_reg_wdata, 3))
    else $error("mask readback");
  AST_UNMAPPED: assert property (rdo && i_reg_addr == 8'h91 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read");
  AST_LIVE_IDLE: assert property (rdo && i_reg_addr == 8'hb4 && i_hysteresis == '0
    && i_impedance == i_calibrated && $past(i_impedance == i_calibrated) |=> o_reg_rdata == 8'h00)
    else $error("live set at rest");
  COV_CFG_WR: cover property (i_reg_wr && i_reg_addr == 8'h90);
  COV_LIVE_RD: cover property (rdo && i_reg_addr == 8'hb4 ##1 o_reg_rdata != 8'h00);
  COV_FILT_RD: cover property (rdo && i_reg_addr == 8'h9a);
endmodule : tkf_key_filter_assertions

bind tkf_key_filter tkf_key_filter_assertions i_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_impedance(i_impedance), .i_calibrated(i_calibrated), .i_hysteresis(i_hysteresis),
  .i_touch_variance_threshold(i_touch_variance_threshold), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack));

/* File: testbench.sv */
// Self-checking bench for the touchkey filter over its byte register port.
// Assumes the checker arrives by its own bind.
`timescale 1ns/10ps
module testbench;
  import tkf_pkg::*;
  logic i_sys_clk = 0;
  logic i_rst = 1;
  logic [TKF_NCH*TKF_IMP_W-1:0] imp = {TKF_NCH{13'h100}};
  logic [TKF_NCH*TKF_IMP_W-1:0] cal = {TKF_NCH{13'h100}};
  logic [TKF_NCH*TKF_THR_W-1:0] thr = {TKF_NCH{13'h010}};
  logic [TKF_NCH*TKF_THR_W-1:0] hys = '0;
  logic wr = 0;
  logic rd = 0;
  logic [7:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata;
  logic ack;
  logic [23:0] v;
  logic [7:0] base [5] = '{8'h90, 8'h92, 8'h96, 8'h9a, 8'hb4};
  // Group one byte per mode; ch3 and ch6 tie, lower channel wins
  logic [7:0] g1 [4] = '{8'h6a, 8'h08, 8'h48, 8'h68};
  int n_errors = 0;
  int tests_run = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  tkf_key_filter i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_impedance(imp), .i_calibrated(cal),
    .i_touch_variance_threshold(thr), .i_hysteresis(hys), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack));
  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge i_sys_clk);
    wr <= 0;
    rd <= 0;
    #1 chk("ack", {23'h0, ack}, 24'h1);
  endtask : acc
  task automatic rd24(input logic [7:0] a, output logic [23:0] r);
    for (int i = 0; i < 3; i++)
    begin
      acc(0, 8'(a + i), 8'h00);
      r[8*i+:8] = rdata;
    end
  endtask : rd24
  task automatic put(input int c, input logic [12:0] x);
    @(posedge i_sys_clk);
    imp[c*13+:13] <= x;
    hys <= {TKF_NCH{13'h002}};
    repeat (10) @(posedge i_sys_clk);
  endtask : put
  task automatic summarize;
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial
  begin
    #100us;
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 0;
    foreach (base[i])
    begin
      rd24(base[i], v);
      chk("reset value", v, 24'h0);
    end
    acc(1, 8'h90, 8'hff);
    acc(0, 8'h90, 8'h00);
    chk("config", {16'h0, rdata}, 24'h0f);
    acc(0, 8'h91, 8'h00);
    chk("unmapped", {16'h0, rdata}, 24'h0);
    acc(1, 8'h93, 8'h00);
    acc(1, 8'h94, 8'h00);
    acc(1, 8'h92, 8'hff);
    rd24(8'h92, v);
    chk("group one", v, 24'h0000ff);
    acc(1, 8'h96, 8'h00);
    acc(1, 8'h98, 8'h00);
    acc(1, 8'h97, 8'hff);
    rd24(8'h96, v);
    chk("group two", v, 24'h00ff00);
    // Deltas 20 40 30 -40 25 35, then 16 equals threshold
    put(1, 13'h114);
    put(3, 13'h128);
    put(5, 13'h11e);
    put(6, 13'h0d8);
    put(9, 13'h119);
    put(10, 13'h123);
    put(16, 13'h110);
    put(17, 13'h111);
    put(20, 13'h132);
    rd24(8'hb4, v);
    chk("live", v, 24'h12066a);
    // Group two mode runs opposite to group one, so swapped fields would show
    for (int m = 0; m < 4; m++)
    begin
      acc(1, 8'h90, 8'(m + 4 * (3 - m)));
      repeat (10) @(posedge i_sys_clk);
      rd24(8'h9a, v);
      chk("filtered", v, {8'h12, m == 2 ? 8'h04 : 8'h06, g1[m]});
    end
    acc(1, 8'h9a, 8'hff);
    acc(1, 8'hb4, 8'h00);
    rd24(8'h9a, v);
    chk("filtered ro", v, 24'h120668);
    put(3, 13'h10f);
    rd24(8'hb4, v);
    chk("live hold", v, 24'h12066a);
    put(3, 13'h10e);
    rd24(8'hb4, v);
    chk("live release", v, 24'h120662);
    rd24(8'h9a, v);
    chk("filtered release", v, 24'h120662);
    summarize();
  end
endmodule : testbench
